// ===== src/static_mac_lookup_table.sv
// eight-entry static mac table with indirect access and forwarding lookup
//
// Notes on behaviour
// - destination lookups consult static and dynamic tables before deciding.
// - source lookups use the dynamic table only; static table ignored.
// - a static hit overrides any dynamic result.
// - aging never removes static entries.
// - only the external processor adds, changes or removes entries.
// - table reachable through the management register access path.
// - exactly eight entries, mac address in the low 48 bits.
// - four-bit filter group id per entry, resets to zero.
// - bit 53 set means group id and mac both compared.
// - bit 52 set forwards despite port transmit or receive disable; here it only drives override_out.
// - bit 51 marks entry valid; only valid entries match; resets zero.
// - bits 50-48 select ports 1, 2, 3; combinations forward to each.
// - map 111 broadcasts to all ports except the ingress port.
`timescale 1ns/1ns
module static_mac_lookup_table
  import static_mac_pkg::*;
(
  // clock, reset, enable
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  // indirect access from the management register path
  input wire logic ctrl_wr_in,
  input wire logic [7:0] ctrl_data_in,
  input wire logic trig_wr_in,
  input wire logic [7:0] trig_data_in,
  input wire logic [ENTRY_WIDTH-1:0] entry_wdata_in,
  output logic [ENTRY_WIDTH-1:0] entry_rdata_out,
  output logic access_done_out,
  // lookup request from the forwarding engine
  input wire logic lookup_req_in,
  input wire logic lookup_is_source_in,
  input wire logic [MAC_WIDTH-1:0] lookup_mac_in,
  input wire logic [GROUP_WIDTH-1:0] filter_group_id_in,
  input wire logic [1:0] ingress_port_in,
  // dynamic table answer and default flood set
  input wire logic dyn_hit_in,
  input wire logic [PORT_COUNT-1:0] dyn_ports_in,
  input wire logic [PORT_COUNT-1:0] flood_ports_in,
  // lookup result
  output logic result_valid_out,
  output logic [PORT_COUNT-1:0] fwd_ports_out,
  output logic static_hit_out,
  output logic override_out,
  output logic [INDEX_WIDTH-1:0] hit_index_out
);
  match_if mif ();

  // table and access state
  logic [ENTRY_WIDTH-1:0] table_q [ENTRY_COUNT];
  logic [ENTRY_WIDTH-1:0] table_d [ENTRY_COUNT];
  logic [7:0] ctrl_q;
  logic [7:0] ctrl_d;
  logic [ENTRY_WIDTH-1:0] rdata_q;
  logic [ENTRY_WIDTH-1:0] rdata_d;
  logic done_q;
  logic done_d;

  // lookup result state
  logic res_valid_q;
  logic res_valid_d;
  logic [PORT_COUNT-1:0] ports_q;
  logic [PORT_COUNT-1:0] ports_d;
  logic shit_q;
  logic shit_d;
  logic ovr_q;
  logic ovr_d;
  logic [INDEX_WIDTH-1:0] hidx_q;
  logic [INDEX_WIDTH-1:0] hidx_d;

  // decoded trigger, matched entry and ingress mask
  logic static_sel;
  logic [INDEX_WIDTH-1:0] trig_index;
  logic [ENTRY_WIDTH-1:0] hit_entry;
  logic [PORT_COUNT-1:0] ingress_mask;

  // parallel compare of the destination against every entry
  static_mac_matcher u_matcher (
    .m (mif.matcher)
  );

  // table contents and probe handed to the matcher
  for (genvar i = 0; i < ENTRY_COUNT; i++)
  begin : g_feed
    assign mif.entries[i] = table_q[i];
  end
  assign mif.dest_mac = lookup_mac_in;
  assign mif.filter_group_id = filter_group_id_in;

  // access decode: only the static table selector is serviced here
  assign static_sel = (ctrl_q[CMD_TABLE_MSB:CMD_TABLE_LSB] == TABLE_SEL_STATIC);
  assign trig_index = trig_data_in[INDEX_WIDTH-1:0];
  assign hit_entry = table_q[mif.hit_index];

  // ingress port as a one-hot mask, port 1 in bit 0
  always_comb
  begin
    ingress_mask = PORTS_NONE;
    if (ingress_port_in < 2'(PORT_COUNT))
    begin
      ingress_mask[ingress_port_in] = 1'b1;
    end
  end

  // next state of table and access registers
  // the table changes only on a processor trigger; nothing here ages it
  always_comb
  begin
    table_d = table_q;
    ctrl_d = ctrl_q;
    rdata_d = rdata_q;
    done_d = 1'b0;
    if (ctrl_wr_in)
    begin
      ctrl_d = ctrl_data_in;
    end
    if (trig_wr_in && static_sel)
    begin
      done_d = 1'b1;
      if (ctrl_q[CMD_READ_BIT])
      begin
        rdata_d = table_q[trig_index];
      end
      else
      begin
        table_d[trig_index] = entry_wdata_in;
      end
    end
  end

  // register the table and access state
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
    begin
      for (int k = 0; k < ENTRY_COUNT; k++)
      begin
        table_q[k] <= ENTRY_RESET;
      end
      ctrl_q <= CTRL_RESET;
      rdata_q <= ENTRY_RESET;
      done_q <= 1'b0;
    end
    else if (ce_in)
    begin
      table_q <= table_d;
      ctrl_q <= ctrl_d;
      rdata_q <= rdata_d;
      done_q <= done_d;
    end
  end

  // forwarding decision, answered one cycle after the request
  always_comb
  begin
    res_valid_d = lookup_req_in;
    ports_d = ports_q;
    shit_d = shit_q;
    ovr_d = ovr_q;
    hidx_d = hidx_q;
    if (lookup_req_in)
    begin
      shit_d = 1'b0;
      ovr_d = 1'b0;
      hidx_d = '0;
      if (lookup_is_source_in)
      begin
        // source side learning never touches the static entries
        ports_d = dyn_ports_in;
      end
      else if (mif.hit)
      begin
        shit_d = 1'b1;
        hidx_d = mif.hit_index;
        ovr_d = hit_entry[OVERRIDE_BIT];
        if (hit_entry[FWD_MAP_MSB:FWD_MAP_LSB] == PORTS_ALL)
        begin
          ports_d = PORTS_ALL & ~ingress_mask;
        end
        else
        begin
          ports_d = hit_entry[FWD_MAP_MSB:FWD_MAP_LSB];
        end
      end
      else if (dyn_hit_in)
      begin
        ports_d = dyn_ports_in;
      end
      else
      begin
        ports_d = flood_ports_in & ~ingress_mask;
      end
    end
  end

  // register the lookup result
  always_ff @(posedge mclk_in)
  begin
    if (!reset_n_in)
    begin
      res_valid_q <= 1'b0;
      ports_q <= PORTS_NONE;
      shit_q <= 1'b0;
      ovr_q <= 1'b0;
      hidx_q <= '0;
    end
    else if (ce_in)
    begin
      res_valid_q <= res_valid_d;
      ports_q <= ports_d;
      shit_q <= shit_d;
      ovr_q <= ovr_d;
      hidx_q <= hidx_d;
    end
  end

  // outputs straight from flops
  assign entry_rdata_out = rdata_q;
  assign access_done_out = done_q;
  assign result_valid_out = res_valid_q;
  assign fwd_ports_out = ports_q;
  assign static_hit_out = shit_q;
  assign override_out = ovr_q;
  assign hit_index_out = hidx_q;
endmodule

// ===== src/static_mac_pkg.sv
// constants and field layout of the static mac lookup table
package static_mac_pkg;
  // table geometry
  localparam int ENTRY_COUNT = 8;
  localparam int INDEX_WIDTH = 3;
  localparam int ENTRY_WIDTH = 58;
  localparam int MAC_WIDTH = 48;
  localparam int GROUP_WIDTH = 4;
  localparam int PORT_COUNT = 3;
  // field positions inside one entry
  localparam int GROUP_ID_MSB = 57;
  localparam int GROUP_ID_LSB = 54;
  localparam int GROUP_QUAL_BIT = 53;
  localparam int OVERRIDE_BIT = 52;
  localparam int VALID_BIT = 51;
  localparam int FWD_MAP_MSB = 50;
  localparam int FWD_MAP_LSB = 48;
  localparam int MAC_MSB = 47;
  // values after reset and the full port set
  localparam logic [ENTRY_WIDTH-1:0] ENTRY_RESET = 58'h000_0000_0000_0000;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [PORT_COUNT-1:0] PORTS_NONE = 3'h0;
  localparam logic [PORT_COUNT-1:0] PORTS_ALL = 3'h7;
  // indirect access control encodings
  localparam logic [7:0] CMD_READ_STATIC = 8'h10;
  localparam logic [7:0] CMD_WRITE_STATIC = 8'h00;
  localparam int CMD_READ_BIT = 4;
  localparam int CMD_TABLE_MSB = 3;
  localparam int CMD_TABLE_LSB = 2;
  localparam logic [1:0] TABLE_SEL_STATIC = 2'h0;
endpackage

// ===== src/match_if.sv
// signals between the table owner and the parallel matcher
`timescale 1ns/1ns
interface match_if;
  import static_mac_pkg::*;
  logic [ENTRY_WIDTH-1:0] entries [ENTRY_COUNT];
  logic [MAC_WIDTH-1:0] dest_mac;
  logic [GROUP_WIDTH-1:0] filter_group_id;
  logic hit;
  logic [INDEX_WIDTH-1:0] hit_index;
  modport owner (output entries, output dest_mac, output filter_group_id, input hit, input hit_index);
  modport matcher (input entries, input dest_mac, input filter_group_id, output hit, output hit_index);
endinterface

// ===== src/static_mac_matcher.sv
// compares a destination address against every static entry at once
`timescale 1ns/1ns
module static_mac_matcher
  import static_mac_pkg::*;
(
  match_if.matcher m
);
  logic [ENTRY_COUNT-1:0] entry_hit;

  // one comparator per entry; invalid entries never match
  for (genvar i = 0; i < ENTRY_COUNT; i++)
  begin : g_cmp
    logic mac_eq;
    logic grp_eq;
    assign mac_eq = (m.entries[i][MAC_MSB:0] == m.dest_mac);
    assign grp_eq = (m.entries[i][GROUP_ID_MSB:GROUP_ID_LSB] == m.filter_group_id);
    // group compare only when the entry asks for it
    assign entry_hit[i] = m.entries[i][VALID_BIT] & mac_eq &
                          (~m.entries[i][GROUP_QUAL_BIT] | grp_eq);
  end

  // lowest index wins if software loaded duplicates
  always_comb
  begin
    m.hit = 1'b0;
    m.hit_index = '0;
    for (int j = ENTRY_COUNT - 1; j >= 0; j--)
    begin
      if (entry_hit[j])
      begin
        m.hit = 1'b1;
        m.hit_index = INDEX_WIDTH'(j);
      end
    end
  end
endmodule

// ===== tb/static_mac_lookup_table_properties.sv
// port assertions for the static mac lookup table
`timescale 1ns/1ns
module static_mac_checker
  import static_mac_pkg::*;
(
  // watched ports
  input wire logic mclk_in,
  input wire logic reset_n_in,
  input wire logic ce_in,
  input wire logic trig_wr_in,
  input wire logic access_done_out,
  input wire logic lookup_req_in,
  input wire logic lookup_is_source_in,
  input wire logic [1:0] ingress_port_in,
  input wire logic dyn_hit_in,
  input wire logic [PORT_COUNT-1:0] dyn_ports_in,
  input wire logic [PORT_COUNT-1:0] flood_ports_in,
  input wire logic result_valid_out,
  input wire logic [PORT_COUNT-1:0] fwd_ports_out,
  input wire logic static_hit_out,
  input wire logic override_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  // a request, then one for a destination
  sequence s_req; ce_in && lookup_req_in; endsequence
  sequence s_dest; s_req ##0 !lookup_is_source_in; endsequence
  a_result_next: assert property (s_req |=> result_valid_out) else $error("no result");
  a_no_spurious: assert property (ce_in && !lookup_req_in |=> !result_valid_out) else $error("stray result");
  a_source_dyn: assert property (s_req ##0 lookup_is_source_in |=> !static_hit_out
    && fwd_ports_out == $past(dyn_ports_in)) else $error("source used static");
  a_dyn_used: assert property (s_dest ##0 dyn_hit_in |=> static_hit_out
    || fwd_ports_out == $past(dyn_ports_in)) else $error("dynamic result lost");
  a_flood_miss: assert property (s_dest ##0 !dyn_hit_in |=> static_hit_out
    || fwd_ports_out == ($past(flood_ports_in) & ~(3'h1 << $past(ingress_port_in)))) else $error("bad flood");
  a_override_hit: assert property (override_out |-> static_hit_out) else $error("override without hit");
  a_done_cause: assert property (access_done_out |-> $past(trig_wr_in)) else $error("done without trigger");
  a_reset_quiet: assert property (disable iff (1'b0) !reset_n_in |=> !result_valid_out
    && !access_done_out) else $error("output during reset");
endmodule
bind static_mac_lookup_table static_mac_checker i_static_mac_checker (.mclk_in, .reset_n_in, .ce_in,
  .trig_wr_in, .access_done_out, .lookup_req_in, .lookup_is_source_in, .ingress_port_in, .dyn_hit_in,
  .dyn_ports_in, .flood_ports_in, .result_valid_out, .fwd_ports_out, .static_hit_out, .override_out);

// ===== tb/mgmt_host_model.sv
// management processor model doing indirect table access
`timescale 1ns/1ns
module mgmt_host_model
  import static_mac_pkg::*;
(
  // clock and answer
  input wire logic mclk_in,
  input wire logic access_done_in,
  // access strobes and data
  output logic ctrl_wr_out,
  output logic [7:0] ctrl_data_out,
  output logic trig_wr_out,
  output logic [7:0] trig_data_out,
  output logic [ENTRY_WIDTH-1:0] wdata_out
);
  // idle strobes from time zero
  initial
  begin
    ctrl_wr_out = 1'b0;
    trig_wr_out = 1'b0;
  end
  // only this model changes entries: control first, then trigger
  task automatic access(input logic [7:0] c, input logic [2:0] i, input logic [ENTRY_WIDTH-1:0] d, output logic ok);
    @(negedge mclk_in);
    ctrl_wr_out = 1'b1;
    ctrl_data_out = c;
    @(negedge mclk_in);
    ctrl_wr_out = 1'b0;
    ctrl_data_out = ~c;
    trig_wr_out = 1'b1;
    trig_data_out = {5'h00, i};
    wdata_out = d;
    @(negedge mclk_in);
    trig_wr_out = 1'b0;
    trig_data_out = ~trig_data_out;
    wdata_out = ~d; // released data is garbage, not the last value
    ok = access_done_in;
  endtask
endmodule

// ===== tb/static_mac_lookup_table_tb_top.sv
// self-checking bench for the static mac lookup table
`timescale 1ns/1ns
module static_mac_lookup_table_tb_top;
  import static_mac_pkg::*;
  typedef struct packed {logic s; logic [47:0] m; logic [3:0] g; logic [1:0] n; logic dh; logic [2:0] dp;
    logic [2:0] fl; logic [2:0] ep; logic eh; logic eo; logic [2:0] ei;} row_type;
  logic mclk_in = 1'b0, reset_n_in = 1'b0, ce_in = 1'b1, ctrl_wr_in, trig_wr_in, access_done_out, ok;
  logic [7:0] ctrl_data_in, trig_data_in;
  logic [57:0] entry_wdata_in, entry_rdata_out, ents [5];
  logic lookup_req_in = 1'b0, lookup_is_source_in = 1'b0, dyn_hit_in = 1'b0, result_valid_out;
  logic static_hit_out, override_out;
  logic [47:0] lookup_mac_in = 48'h0;
  logic [3:0] filter_group_id_in = 4'h0;
  logic [1:0] ingress_port_in = 2'h0;
  logic [2:0] dyn_ports_in = 3'h0, flood_ports_in = 3'h0, fwd_ports_out, hit_index_out;
  int err_count = 0, total_checks = 0, cyc = 0;
  row_type rows [8] = '{'{0,48'hA,0,0,1,2,7,1,1,1,0}, '{1,48'hA,0,0,1,2,7,2,0,0,0}, '{0,48'hB,5,1,0,0,7,5,1,0,1},
    '{0,48'hB,4,0,0,0,7,6,0,0,0}, '{0,48'hC,0,0,1,1,7,1,0,0,0}, '{0,48'hD,0,0,0,0,7,6,1,0,3},
    '{0,48'hE,0,2,0,0,7,4,1,0,7}, '{0,48'hF,0,3,0,0,3,3,0,0,0}};
  static_mac_lookup_table i_static_mac_lookup_table (.mclk_in, .reset_n_in, .ce_in, .ctrl_wr_in, .ctrl_data_in,
    .trig_wr_in, .trig_data_in, .entry_wdata_in, .entry_rdata_out, .access_done_out, .lookup_req_in,
    .lookup_is_source_in, .lookup_mac_in, .filter_group_id_in, .ingress_port_in, .dyn_hit_in, .dyn_ports_in,
    .flood_ports_in, .result_valid_out, .fwd_ports_out, .static_hit_out, .override_out, .hit_index_out);
  mgmt_host_model i_mgmt_host_model (.mclk_in, .access_done_in(access_done_out), .ctrl_wr_out(ctrl_wr_in),
    .ctrl_data_out(ctrl_data_in), .trig_wr_out(trig_wr_in), .trig_data_out(trig_data_in),
    .wdata_out(entry_wdata_in));
  // 25 mhz clock
  initial
  begin
    forever #20 mclk_in = ~mclk_in;
  end
  // hang guard, the run needs well under two hundred cycles
  always @(posedge mclk_in)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      err_count++;
      end_sim();
    end
  end
  task automatic chk(input logic [63:0] g, input logic [63:0] e);
    total_checks++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH t=%0t got %0h exp %0h", $time, g, e);
    end
  endtask
  // one request cycle, result looked at one cycle later
  task automatic look(input row_type r);
    @(negedge mclk_in);
    {lookup_req_in, lookup_is_source_in, lookup_mac_in, filter_group_id_in} = {1'b1, r.s, r.m, r.g};
    {ingress_port_in, dyn_hit_in, dyn_ports_in, flood_ports_in} = {r.n, r.dh, r.dp, r.fl};
    @(negedge mclk_in);
    lookup_req_in = 1'b0;
    chk(result_valid_out, 1);
    chk(fwd_ports_out, r.ep);
    chk({static_hit_out, override_out, hit_index_out}, {r.eh, r.eo, r.ei});
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // reset, fill, table-driven lookups, delete, refusal and enable, then reset in mid-run
  initial
  begin
    ents = '{{7'h03, 3'h1, 48'hA}, {7'h2D, 3'h7, 48'hB}, {7'h00, 3'h2, 48'hC}, {7'h01, 3'h6, 48'hD}, {7'h01, 3'h4, 48'hE}};
    repeat (8) @(negedge mclk_in);
    reset_n_in = 1'b1;
    i_mgmt_host_model.access(CMD_READ_STATIC, 3'h4, 58'h0, ok);
    chk({ok, entry_rdata_out}, {1'b1, ENTRY_RESET});
    for (int i = 0; i < 5; i++)
    begin
      i_mgmt_host_model.access(CMD_WRITE_STATIC, (i == 4) ? 3'h7 : 3'(i), ents[i], ok);
      chk(ok, 1);
    end
    i_mgmt_host_model.access(CMD_READ_STATIC, 3'h7, 58'h0, ok);
    chk(entry_rdata_out, ents[4]);
    $display("access test done");
    foreach (rows[i])
      look(rows[i]);
    $display("lookup table done");
    i_mgmt_host_model.access(CMD_WRITE_STATIC, 3'h0, ENTRY_RESET, ok);
    chk(ok, 1);
    look(row_type'{0, 48'hA, 0, 0, 1, 2, 7, 2, 0, 0, 0});
    $display("delete test done");
    // a trigger aimed at another table is refused and leaves the static entries alone
    i_mgmt_host_model.access(8'h04, 3'h1, ENTRY_RESET, ok);
    chk(ok, 0);
    chk(entry_rdata_out, ents[4]);
    look(rows[2]);
    // enable low freezes the standing result and takes no request
    ce_in = 1'b0;
    @(negedge mclk_in);
    lookup_req_in = 1'b1;
    chk({result_valid_out, static_hit_out, fwd_ports_out}, {2'b11, 3'h5});
    @(negedge mclk_in);
    {ce_in, lookup_req_in} = 2'b10;
    chk(result_valid_out, 1);
    @(negedge mclk_in);
    chk(result_valid_out, 0);
    $display("refusal test done");
    // reset in mid-run clears the outputs and every entry
    reset_n_in = 1'b0;
    repeat (2) @(negedge mclk_in);
    chk({result_valid_out, fwd_ports_out, static_hit_out, override_out, hit_index_out, access_done_out}, 0);
    chk(entry_rdata_out, ENTRY_RESET);
    reset_n_in = 1'b1;
    look(row_type'{0, 48'hB, 5, 1, 0, 0, 3, 1, 0, 0, 0});
    $display("reset test done");
    end_sim();
  end
endmodule
